/* File: hw/tbap_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tbap_top
  import tbap_pkg::*;
#(
  parameter int unsigned TR0_CYC = TR0_CYC_DFLT,
  parameter int unsigned TR1_CYC = TR1_CYC_DFLT,
  parameter int unsigned FIFO_DEPTH = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // command bytes from the demodulator
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_eof_i,
  // answer bytes to the modulator
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic [7:0] tx_data_o,
  output logic tx_last_o,
  output logic tx_sc_o,
  output logic active_o
);
  // wait counters are 16 bits wide
  if (TR0_CYC < 1 || TR0_CYC > 65535 || TR1_CYC < 1 ||
      TR1_CYC > 65535) begin : g_bad_time
    $error("tbap_top guard counts out of range");
  end
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic ack_ff; // bus answer
  logic [31:0] dat_ff; // read data
  logic [31:0] rd_w; // read mux
  logic [31:0] ctrl_ff; // fwi and enable
  logic [31:0] id_ff; // card identifier
  logic [15:0] err_ff; // crc failures
  logic [15:0] nxt_err;
  logic [3:0] rx_cnt_ff; // bytes in current frame
  logic [15:0] rx_crc_ff; // running crc of command
  logic id_ok_ff; // identifier bytes matched so far
  logic [7:0] cmd_ff, p1_ff, p2_ff, p3_ff, p4_ff; // captured bytes
  logic [1:0] tr0_code_ff, tr1_code_ff; // decoded guard codes
  logic r212_ff; // attrib chose 212 kbps
  tbap_st_t st_ff, nxt_st; // protocol state
  tbap_ph_t ph_ff, nxt_ph; // answer phase
  logic [15:0] wt_ff; // cycles in current phase
  logic [3:0] idx_ff; // next answer byte
  logic [15:0] tx_crc_ff; // running crc of answer
  logic [3:0] fwi_ff; // fwi frozen for this answer
  logic sc_ff; // subcarrier on
  tbap_strm_if #(.W(9)) in_if ();
  tbap_strm_if #(.W(9)) out_if ();
  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire logic req_w = wb_cyc_i & wb_stb_i & ~ack_ff;
  // write lands at the edge where the master sees ack
  wire logic wr_w = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
  wire logic wr_ctrl_w = wr_w & (wb_adr_i == REG_CTRL);
  wire logic wr_id_w = wr_w & (wb_adr_i == REG_ID);
  wire logic wr_err_w = wr_w & (wb_adr_i == REG_ERR);
  wire logic en_w = ctrl_ff[CTRL_EN_BIT];
  wire logic [31:0] stat_w = {8'h00,
    fs_nom(1'b1, tr1_code_ff, r212_ff), fs_nom(1'b0, tr0_code_ff, r212_ff),
    (ph_ff != PH_OFF), r212_ff, tr1_code_ff, tr0_code_ff, st_ff};
  // byte-lane merge for writes
  function automatic logic [31:0] wmask(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = n[8*b +: 8];
    end
    return r;
  endfunction
  // read mux, unmapped words read zero
  always_comb begin
    if (wb_adr_i == REG_CTRL) rd_w = ctrl_ff;
    else if (wb_adr_i == REG_ID) rd_w = id_ff;
    else if (wb_adr_i == REG_STAT) rd_w = stat_w;
    else if (wb_adr_i == REG_ERR) rd_w = {16'h0000, err_ff};
    else rd_w = 32'h0000_0000;
  end
  // one wait state answer, ack drops after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req_w;
      dat_ff <= req_w ? rd_w : dat_ff;
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  // software registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= CTRL_RST;
      id_ff <= ID_RST;
    end else begin
      ctrl_ff <= wr_ctrl_w ? wmask(ctrl_ff, wb_dat_i, wb_sel_i) : ctrl_ff;
      id_ff <= wr_id_w ? wmask(id_ff, wb_dat_i, wb_sel_i) : id_ff;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // command receive; the tag is half duplex, so bytes are
  // ignored while an answer is pending or on air
  wire logic rx_take_w = rx_valid_i & en_w & (ph_ff == PH_OFF);
  wire logic rx_end_w = rx_eof_i & en_w & (ph_ff == PH_OFF);
  wire logic crc_ok_w = (rx_crc_ff == CRC_RES);
  wire logic in_id_w = (rx_cnt_ff >= POS_ID) && (rx_cnt_ff < POS_P1);
  // equal rates, both within 106/212, and a frame size we take
  wire logic rate_ok_w = (p2_ff[7:6] == p2_ff[5:4]) &&
                         (p2_ff[7:6] <= RATE_212);
  wire logic size_ok_w = (p2_ff[3:0] >= FSZ_MIN) &&
                         (p2_ff[3:0] <= FSZ_MAX);
  wire logic att_ok_w = rate_ok_w & size_ok_w & (p3_ff == ATT_P3) &
                        (p4_ff[3:0] == ATT_P4_CID);
  // slot bits of the request are not looked at
  wire logic req_hit_w = rx_end_w & crc_ok_w & (cmd_ff == CMD_REQ) &
                         (rx_cnt_ff == REQ_LEN) &
                         (st_ff != ST_ACTIVE);
  wire logic att_hit_w = rx_end_w & crc_ok_w & (cmd_ff == CMD_ATTRIB) &
                         (rx_cnt_ff == ATT_LEN) & (st_ff == ST_READY) &
                         id_ok_ff & att_ok_w;
  wire logic crc_bad_w = rx_end_w & (rx_cnt_ff != 4'h0) & ~crc_ok_w;
  // counter, crc and identifier match run per byte
  always_ff @(posedge clk_i) begin
    if (rst_i || rx_end_w) begin
      rx_cnt_ff <= 4'h0;
      rx_crc_ff <= CRC_INIT;
      id_ok_ff <= 1'b1;
    end else if (rx_take_w) begin
      rx_cnt_ff <= (rx_cnt_ff == CNT_MAX) ? CNT_MAX : rx_cnt_ff + 4'h1;
      rx_crc_ff <= crc_b(rx_crc_ff, rx_data_i);
      if (in_id_w && rx_data_i != id_byte(id_ff, rx_cnt_ff)) begin
        id_ok_ff <= 1'b0;
      end
    end
  end
  // header bytes captured by position
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {cmd_ff, p1_ff, p2_ff, p3_ff, p4_ff} <= '0;
    end else if (rx_take_w) begin
      if (rx_cnt_ff == POS_CODE) cmd_ff <= rx_data_i;
      if (rx_cnt_ff == POS_P1) p1_ff <= rx_data_i;
      if (rx_cnt_ff == POS_P2) p2_ff <= rx_data_i;
      if (rx_cnt_ff == POS_P3) p3_ff <= rx_data_i;
      if (rx_cnt_ff == POS_P4) p4_ff <= rx_data_i;
    end
  end
  // crc failures; a failure in the clearing cycle still counts
  assign nxt_err = (wr_err_w ? 16'h0000 : err_ff) + {15'h0000, crc_bad_w};
  always_ff @(posedge clk_i) begin
    err_ff <= rst_i ? 16'h0000 : nxt_err;
  end
  ////////////////////////////////////////////////////////////////////////////
  // guard codes kept on accept; bits 3-0 of param1 are not used,
  // so frames always carry their start and end marks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tr0_code_ff <= 2'h0;
      tr1_code_ff <= 2'h0;
      r212_ff <= 1'b0;
    end else if (att_hit_w) begin
      tr0_code_ff <= (p1_ff[7:6] == RES_CODE) ? 2'h0 : p1_ff[7:6];
      tr1_code_ff <= (p1_ff[5:4] == RES_CODE) ? 2'h0 : p1_ff[5:4];
      r212_ff <= (p2_ff[7:6] == RATE_212);
    end
  end
  // protocol state; clearing enable drops back to idle
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: if (req_hit_w) nxt_st = ST_READY;
      ST_READY: if (att_hit_w) nxt_st = ST_ACTIVE;
      ST_ACTIVE: nxt_st = ST_ACTIVE;
      default: nxt_st = ST_IDLE;
    endcase
    if (!en_w) nxt_st = ST_IDLE;
  end
  always_ff @(posedge clk_i) begin
    st_ff <= rst_i ? ST_IDLE : nxt_st;
  end
  assign active_o = (st_ff == ST_ACTIVE);
  ////////////////////////////////////////////////////////////////////////////
  // answer sequencer: wait the longest TR0 and TR1 whatever the
  // reader asked, since the shorter codes are never shorter than safe
  wire logic push_w = (ph_ff == PH_SEND) & in_if.ready;
  wire logic out_end_w = tx_valid_o & tx_ready_i & tx_last_o;
  always_comb begin
    nxt_ph = ph_ff;
    case (ph_ff)
      PH_OFF: if (req_hit_w) nxt_ph = PH_TR0;
      PH_TR0: if (wt_ff == 16'(TR0_CYC - 1)) nxt_ph = PH_TR1;
      PH_TR1: if (wt_ff == 16'(TR1_CYC - 1)) nxt_ph = PH_SEND;
      PH_SEND: if (push_w && idx_ff == ANS_LEN - 4'h1) nxt_ph = PH_DRAIN;
      PH_DRAIN: if (out_end_w) nxt_ph = PH_OFF;
      default: nxt_ph = PH_OFF;
    endcase
  end
  // phase, wait counter and subcarrier
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_ff <= PH_OFF;
      wt_ff <= 16'h0000;
      sc_ff <= 1'b0;
    end else begin
      ph_ff <= nxt_ph;
      wt_ff <= (nxt_ph != ph_ff) ? 16'h0000 : wt_ff + 16'h0001;
      sc_ff <= (nxt_ph == PH_TR1) || (nxt_ph == PH_SEND) ||
               (nxt_ph == PH_DRAIN);
    end
  end
  assign tx_sc_o = sc_ff;
  // byte index, answer crc and frozen fwi
  always_ff @(posedge clk_i) begin
    if (rst_i || ph_ff == PH_OFF) begin
      idx_ff <= 4'h0;
      tx_crc_ff <= CRC_INIT;
      fwi_ff <= rst_i ? 4'h0 : ctrl_ff[3:0];
    end else if (push_w) begin
      idx_ff <= idx_ff + 4'h1;
      tx_crc_ff <= (idx_ff < POS_CRC) ? crc_b(tx_crc_ff, in_if.data[7:0])
                                      : tx_crc_ff;
    end
  end
  // answer byte by position
  function automatic logic [7:0] ans_byte(input logic [3:0] i,
                                          input logic [31:0] id,
                                          input logic [3:0] fwi,
                                          input logic [15:0] crc);
    if (i == POS_CODE) return ANS_CODE;
    else if (i < POS_P1) return id_byte(id, i);
    else if (i < POS_INFO1) return APP_DATA;
    else if (i == POS_INFO1) return INFO1;
    else if (i == POS_INFO2) return INFO2;
    else if (i == POS_INFO3) return {fwi, ADC_PROP, FO_NONE};
    else if (i == POS_CRC) return ~crc[7:0];
    else return ~crc[15:8];
  endfunction
  assign in_if.valid = (ph_ff == PH_SEND);
  assign in_if.data = {(idx_ff == ANS_LEN - 4'h1),
                       ans_byte(idx_ff, id_ff, fwi_ff, tx_crc_ff)};
  // four-word buffer ahead of the modulator; its ready stalls the sequencer
  tbap_fifo #(.W(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .s(in_if),
    .m(out_if)
  );
  assign tx_valid_o = out_if.valid;
  assign out_if.ready = tx_ready_i;
  assign tx_data_o = out_if.data[7:0];
  assign tx_last_o = out_if.data[8];
  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] gap_ff; // cycles since last accepted request
  always_ff @(posedge clk_i) begin
    gap_ff <= (rst_i || req_hit_w) ? 32'h0 : gap_ff + 32'h1;
  end
  property p_app_zero;
    push_w && idx_ff >= POS_P1 && idx_ff < POS_INFO1 |-> in_if.data == 9'h0;
  endproperty
  a_app_zero: assert property (p_app_zero)
    else $error("application data not zero");
  property p_info1;
    push_w && idx_ff == POS_INFO1 |-> in_if.data[7:0] == 8'h91;
  endproperty
  a_info1: assert property (p_info1)
    else $error("first info byte wrong");
  property p_info2_hi;
    push_w && idx_ff == POS_INFO2 |-> in_if.data[7:4] == 4'h8;
  endproperty
  a_info2_hi: assert property (p_info2_hi)
    else $error("frame size nibble wrong");
  property p_info2_lo;
    push_w && idx_ff == POS_INFO2 |-> in_if.data[3:0] == 4'h1;
  endproperty
  a_info2_lo: assert property (p_info2_lo)
    else $error("protocol type wrong");
  property p_fwi;
    push_w && idx_ff == POS_INFO3 |-> in_if.data[7:4] == $past(fwi_ff);
  endproperty
  a_fwi: assert property (p_fwi)
    else $error("fwi nibble wrong");
  property p_adc;
    push_w && idx_ff == POS_INFO3 |-> in_if.data[3:2] == 2'b00;
  endproperty
  a_adc: assert property (p_adc)
    else $error("coding bits not zero");
  property p_fo;
    push_w && idx_ff == POS_INFO3 |-> in_if.data[1:0] == 2'b00;
  endproperty
  a_fo: assert property (p_fo)
    else $error("frame option bits not zero");
  property p_att_active;
    att_hit_w && !wr_ctrl_w |=> st_ff == ST_ACTIVE ##1 active_o;
  endproperty
  a_att_active: assert property (p_att_active)
    else $error("attrib did not activate");
  property p_id_match;
    $rose(st_ff == ST_ACTIVE) |-> $past(id_ok_ff) && $past(att_hit_w);
  endproperty
  a_id_match: assert property (p_id_match)
    else $error("activated without identifier match");
  property p_tr0_min;
    $rose(tx_sc_o) |-> gap_ff >= TR0_CYC;
  endproperty
  a_tr0_min: assert property (p_tr0_min)
    else $error("subcarrier before TR0");
  property p_tr1_min;
    push_w && idx_ff == POS_CODE |-> tx_sc_o && gap_ff >= TR0_CYC + TR1_CYC;
  endproperty
  a_tr1_min: assert property (p_tr1_min)
    else $error("data before TR1");
  property p_res_tr0;
    att_hit_w && p1_ff[7:6] == 2'b11 |=> tr0_code_ff == 2'b00;
  endproperty
  a_res_tr0: assert property (p_res_tr0)
    else $error("reserved TR0 code kept");
  property p_res_tr1;
    att_hit_w && p1_ff[5:4] == 2'b11 |=> tr1_code_ff == 2'b00;
  endproperty
  a_res_tr1: assert property (p_res_tr1)
    else $error("reserved TR1 code kept");
  property p_req_answer;
    req_hit_w |=> ph_ff == PH_TR0 ##[1:2] !tx_sc_o;
  endproperty
  a_req_answer: assert property (p_req_answer)
    else $error("request not answered");
  property p_silent;
    rx_end_w && cmd_ff == CMD_ATTRIB && p2_ff[7:6] != p2_ff[5:4] &&
      st_ff != ST_ACTIVE |=>
      st_ff != ST_ACTIVE && ph_ff == PH_OFF;
  endproperty
  a_silent: assert property (p_silent)
    else $error("answered unequal rates");
  property p_crc_drop;
    crc_bad_w && !wr_ctrl_w |=> ph_ff == PH_OFF && st_ff == $past(st_ff);
  endproperty
  a_crc_drop: assert property (p_crc_drop)
    else $error("bad crc command acted on");
  c_answer: cover property (push_w && idx_ff == ANS_LEN - 4'h1);
  c_active: cover property ($rose(st_ff == ST_ACTIVE));
  c_crc_bad: cover property (crc_bad_w);
  c_full: cover property ((ph_ff == PH_SEND) && !in_if.ready);
endmodule // tbap_top
`default_nettype wire

/* File: hw/tbap_pkg.sv */
// Function
// - answer: 0x50, identifier, zero data, info, CRC
// - first info byte is 0x91
// - second info byte upper nibble: 256-byte frames
// - protocol type 0001b; reader then waits TR2
// - third info byte upper nibble carries FWI
// - third info bits 3-2 zero: proprietary coding
// - third info bits 1-0 zero: no NAD/CID
// - accepted ATTRIB 0x1D enters command-processing state
// - ATTRIB identifier equals our answered identifier
// - decode TR0 code, always apply 64/fs minimum
// - decode TR1 code, always use 80/fs minimum
// - reserved TR0 code 11b treated as 00b
// - reserved TR1 11b as 00b; SOF/EOF kept
// - answer REQB/WUPB 0x05 as single slot
// - silent on unequal or unsupported ATTRIB settings
package tbap_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // command and answer codes
  localparam logic [7:0] CMD_REQ = 8'h05;
  localparam logic [7:0] CMD_ATTRIB = 8'h1d;
  localparam logic [7:0] ANS_CODE = 8'h50;
  localparam logic [7:0] APP_DATA = 8'h00;
  localparam logic [7:0] INFO1 = 8'h91;
  localparam logic [7:0] INFO2 = 8'h81;
  localparam logic [1:0] ADC_PROP = 2'h0;
  localparam logic [1:0] FO_NONE = 2'h0;
  localparam logic [7:0] ATT_P3 = 8'h01;
  localparam logic [3:0] ATT_P4_CID = 4'h0;
  // frame lengths, CRC_B included
  localparam logic [3:0] REQ_LEN = 4'h5;
  localparam logic [3:0] ATT_LEN = 4'hb;
  localparam logic [3:0] ANS_LEN = 4'he;
  // byte positions inside frames
  localparam logic [3:0] POS_CODE = 4'h0;
  localparam logic [3:0] POS_ID = 4'h1;
  localparam logic [3:0] POS_P1 = 4'h5;
  localparam logic [3:0] POS_P2 = 4'h6;
  localparam logic [3:0] POS_P3 = 4'h7;
  localparam logic [3:0] POS_P4 = 4'h8;
  localparam logic [3:0] POS_INFO1 = 4'h9;
  localparam logic [3:0] POS_INFO2 = 4'ha;
  localparam logic [3:0] POS_INFO3 = 4'hb;
  localparam logic [3:0] POS_CRC = 4'hc;
  localparam logic [3:0] CNT_MAX = 4'hf;
  // crc_b, reflected, residue after data plus inverted crc
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_RES = 16'hf0b8;
  // rate codes and reader frame sizes
  localparam logic [1:0] RATE_212 = 2'h1;
  localparam logic [1:0] RES_CODE = 2'h3;
  localparam logic [3:0] FSZ_MIN = 4'h5;
  localparam logic [3:0] FSZ_MAX = 4'h8;
  // guard times in subcarrier periods
  localparam logic [7:0] TR0_FS = 8'h40;
  localparam logic [7:0] TR1_FS = 8'h50;
  localparam logic [7:0] TR_48 = 8'h30;
  localparam logic [7:0] TR_32 = 8'h20;
  localparam logic [7:0] TR_16 = 8'h10;
  localparam logic [7:0] TR_8 = 8'h08;
  localparam longint unsigned FS_HZ = 848000;
  localparam longint unsigned CLK_HZ = 250000000;
  // least times, rounded up to whole clocks
  localparam int unsigned TR0_CYC_DFLT =
    int'((64'(TR0_FS) * CLK_HZ + FS_HZ - 1) / FS_HZ);
  localparam int unsigned TR1_CYC_DFLT =
    int'((64'(TR1_FS) * CLK_HZ + FS_HZ - 1) / FS_HZ);
  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ID = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_ERR = 8'h0c;
  localparam logic [31:0] CTRL_RST = 32'h0000_0100;
  localparam logic [31:0] ID_RST = 32'h0000_0000;
  localparam int unsigned CTRL_EN_BIT = 8;
  ////////////////////////////////////////////////////////////////////////////
  // states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READY = 2'b01,
    ST_ACTIVE = 2'b10
  } tbap_st_t;
  typedef enum logic [2:0] {
    PH_OFF = 3'b000,
    PH_TR0 = 3'b001,
    PH_TR1 = 3'b010,
    PH_SEND = 3'b011,
    PH_DRAIN = 3'b100
  } tbap_ph_t;
  ////////////////////////////////////////////////////////////////////////////
  // one byte of crc_b, lsb first
  function automatic logic [15:0] crc_b(input logic [15:0] c,
                                        input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
  // identifier byte at frame position 1..4, msb first
  function automatic logic [7:0] id_byte(input logic [31:0] id,
                                         input logic [3:0] pos);
    case (pos)
      4'h1: return id[31:24];
      4'h2: return id[23:16];
      4'h3: return id[15:8];
      default: return id[7:0];
    endcase
  endfunction
  // nominal guard time in fs periods for a code and rate
  function automatic logic [7:0] fs_nom(input logic is_tr1,
                                        input logic [1:0] code,
                                        input logic r212);
    case (code)
      2'h1: return r212 ? TR_32 : (is_tr1 ? TR0_FS : TR_48);
      2'h2: return r212 ? TR_8 : TR_16;
      default: return is_tr1 ? TR1_FS : TR0_FS;
    endcase
  endfunction
endpackage

/* File: hw/tbap_strm_if.sv */
`timescale 1ns/1ns
`default_nettype none
// byte stream with valid/ready handshake
interface tbap_strm_if #(
  parameter int unsigned W = 9
);
  logic valid; // source holds a word
  logic ready; // sink takes it this cycle
  logic [W-1:0] data; // word
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: hw/tbap_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module tbap_fifo #(
  parameter int unsigned W = 9,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fill and drain sides
  tbap_strm_if.snk s,
  tbap_strm_if.src m
);
  localparam int unsigned AW = $clog2(DEPTH);
  // pointer compare needs a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("tbap_fifo depth must be a power of two");
  end
  logic [W-1:0] mem_ff [DEPTH]; // storage words
  logic [AW:0] wr_ff; // write pointer, extra wrap bit
  logic [AW:0] rd_ff; // read pointer, extra wrap bit
  wire logic full_w = (wr_ff[AW-1:0] == rd_ff[AW-1:0]) &&
                      (wr_ff[AW] != rd_ff[AW]);
  wire logic empty_w = (wr_ff == rd_ff);
  wire logic wr_en_w = s.valid & ~full_w;
  wire logic rd_en_w = m.ready & ~empty_w;
  assign s.ready = ~full_w;
  assign m.valid = ~empty_w;
  assign m.data = mem_ff[rd_ff[AW-1:0]];
  // storage write, no reset needed for data
  always_ff @(posedge clk_i) begin
    if (wr_en_w) begin
      mem_ff[wr_ff[AW-1:0]] <= s.data;
    end
  end
  // pointers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= wr_ff + (AW + 1)'(wr_en_w);
      rd_ff <= rd_ff + (AW + 1)'(rd_en_w);
    end
  end
endmodule // tbap_fifo
`default_nettype wire

/* File: sim/tbap_rdr.sv */
`timescale 1ns/1ns
`default_nettype none
// reader model: sends framed commands, takes answer bytes
module tbap_rdr #(
  parameter int unsigned GAP = 40 // reader wait, shortened for sim
) (
  // clock and stall
  input wire logic clk_i,
  input wire logic stall_i,
  // command bytes
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_eof_o,
  // answer bytes
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o
);
  logic [7:0] got[$]; // answer bytes taken
  initial begin
    rx_valid_o = 1'h0;
    rx_data_o = 8'h00;
    rx_eof_o = 1'h0;
    tx_ready_o = 1'h0;
  end
  // slow taker: ready every other cycle, none while stalled
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got.push_back(tx_data_i);
    end
    tx_ready_o <= ~stall_i & ~tx_ready_o;
  end
  // crc_b, inverted as sent on air
  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] r;
    r = 16'hffff;
    foreach (b[i]) begin
      r = r ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) begin
        r = r[0] ? ((r >> 1) ^ 16'h8408) : (r >> 1);
      end
    end
    return ~r;
  endfunction
  // one frame; data line shows the inverse once released
  task automatic send(input logic [7:0] f[$], input logic bad);
    logic [15:0] c;
    c = crc(f) ^ {15'h0, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    repeat (GAP) @(posedge clk_i);
    foreach (f[i]) begin
      @(posedge clk_i);
      rx_valid_o <= 1'h1;
      rx_data_o <= f[i];
      @(posedge clk_i);
      rx_valid_o <= 1'h0;
      rx_data_o <= ~f[i];
    end
    @(posedge clk_i);
    rx_eof_o <= 1'h1;
    @(posedge clk_i);
    rx_eof_o <= 1'h0;
  endtask
endmodule // tbap_rdr
`default_nettype wire

/* File: sim/typeb_answer_and_attrib_parse_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module typeb_answer_and_attrib_parse_bench;
  import tbap_pkg::*;
  logic clk_i = 1'h0, rst_i = 1'h1, stall = 1'h1;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00, rx_data_i, tx_data_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic rx_valid_i, rx_eof_i, tx_valid_o, tx_ready_i, tx_last_o;
  logic tx_sc_o, active_o;
  logic [7:0] e[$]; // expected answer
  logic [15:0] c;
  int n, nb = 0, nlast = 0, miscompares = 0, checks_done = 0;
  tbap_top #(.TR0_CYC(20), .TR1_CYC(30)) i_tbap_top (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_eof_i(rx_eof_i),
    .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
    .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_sc_o(tx_sc_o),
    .active_o(active_o));
  tbap_rdr i_tbap_rdr (.clk_i(clk_i), .stall_i(stall),
    .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_eof_o(rx_eof_i),
    .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
    .tx_ready_o(tx_ready_i));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // count handed-over answer bytes and note where the last mark sat
  always @(posedge clk_i) begin
    if (tx_valid_o && tx_ready_i) begin
      nb++;
      if (tx_last_o) nlast = nb;
    end
  end
  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] w);
    checks_done++;
    if (g !== w) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, g, w);
    end
  endtask
  // classic wishbone cycle; request held until the edge that sees ack,
  // data taken and request dropped at that same edge
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'h1 && k < 100);
    chk(32'(wb_ack_o), 32'h1);
    r = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] w);
    logic [31:0] r;
    wb(1'h0, a, 32'h0, r);
    chk(r, w);
  endtask
  // attrib frame, then look at the state output
  task automatic att(input logic [31:0] id, input logic [7:0] p1,
                     input logic [7:0] p2, input logic want);
    i_tbap_rdr.send('{CMD_ATTRIB, id[31:24], id[23:16], id[15:8],
                      id[7:0], p1, p2, 8'h01, 8'h00}, 1'h0);
    repeat (4) @(negedge clk_i);
    chk(32'(active_o), 32'(want));
  endtask
  task automatic end_of_test;
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #60000;
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(REG_CTRL, CTRL_RST);
    rd(8'h40, 32'h0);
    wb(1'h1, REG_CTRL, 32'h0000_010a, q);
    wb(1'h1, REG_ID, 32'h1234_5678, q);
    i_tbap_rdr.send('{CMD_REQ, 8'h00, 8'h00}, 1'h1);
    repeat (80) @(negedge clk_i);
    chk(32'(tx_sc_o), 32'h0);
    rd(REG_ERR, 32'h1);
    i_tbap_rdr.send('{CMD_REQ, 8'h00, 8'h07}, 1'h0);
    for (n = 0; n < 999 && tx_sc_o !== 1'h1; n++) @(negedge clk_i);
    chk(32'(n >= 19 && n < 999), 32'h1);
    for (n = 0; n < 999 && tx_valid_o !== 1'h1; n++) @(negedge clk_i);
    chk(32'(n >= 30 && n < 999), 32'h1);
    repeat (20) @(negedge clk_i);
    chk(32'(tx_sc_o), 32'h1);
    stall <= 1'h0;
    for (n = 0; n < 300 && i_tbap_rdr.got.size() < 14; n++) @(negedge clk_i);
    repeat (3) @(negedge clk_i);
    chk(32'(tx_sc_o), 32'h0);
    e = '{8'h50, 8'h12, 8'h34, 8'h56, 8'h78, 8'h00, 8'h00, 8'h00, 8'h00,
          8'h91, 8'h81, 8'ha0};
    c = i_tbap_rdr.crc(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    chk(32'(i_tbap_rdr.got.size()), 32'd14);
    chk(32'(nlast), 32'd14);
    foreach (e[i]) begin
      if (i < 9 || i > 11) chk(32'(i_tbap_rdr.got[i]), 32'(e[i]));
    end
    chk(32'(i_tbap_rdr.got[9]), 32'h91);
    chk(32'(i_tbap_rdr.got[10]), 32'h81);
    chk(32'(i_tbap_rdr.got[11]), 32'ha0);
    att(32'h1234_5678, 8'h00, 8'h48, 1'h0);
    att(32'h1234_5679, 8'h00, 8'h08, 1'h0);
    att(32'h1234_5678, 8'hf3, 8'h08, 1'h1);
    rd(REG_STAT, 32'h0050_4002);
    end_of_test();
  end
endmodule // typeb_answer_and_attrib_parse_bench
`default_nettype wire
